// ===== rtl/rst_backup_pkg.sv
// Constants for the reset and RAM back-up controller.
// Assumes a single 20 MHz system clock; one machine cycle equals one clock.
package rst_backup_pkg;
    localparam int PC_W = 14;
    localparam int NIB_W = 4;
    localparam int PORT_W = 22;
    localparam int PU_W = 5;
    localparam logic [PC_W-1:0] PC_RESET = 14'h0000;
    localparam logic [NIB_W-1:0] NIB_RESET = 4'h0;
    localparam logic [PORT_W-1:0] LATCH_RESET = 22'h3FFFFF;
    localparam int NUM_NIB_REGS = 5;
    localparam int IDX_EXT_INT_CTRL = 0;
    localparam int IDX_PULLUP0 = 1;
    localparam int IDX_PULLUP1 = 2;
    localparam int IDX_PULLUP2 = 3;
    localparam int IDX_CONV_CTRL = 4;
    localparam int POR_CYCLES = 4;
    typedef enum logic [3:0] {
        ST_RESET = 4'h1,
        ST_RUN = 4'h2,
        ST_ARMED = 4'h4,
        ST_BACKUP = 4'h8
    } seq_state_e;
endpackage

// ===== rtl/nib_regs_if.sv
// Interface carrying nibble register file signals between controller and store.
// Assumes one clock domain.
`timescale 1ns/10ps
interface nib_regs_if;
    import rst_backup_pkg::*;
    logic clear;
    logic wr_en;
    logic [2:0] wr_idx;
    logic [NIB_W-1:0] wr_data;
    logic [NUM_NIB_REGS*NIB_W-1:0] rd_all;
    modport ctrl (output clear, output wr_en, output wr_idx, output wr_data, input rd_all);
    modport store (input clear, input wr_en, input wr_idx, input wr_data, output rd_all);
endinterface

// ===== rtl/nib_reg_store.sv
// Small register store for the nibble control registers.
// Assumes clear comes from the reset controller on the same clock.
`timescale 1ns/10ps
module nib_reg_store
    import rst_backup_pkg::*;
(
    input wire logic clk_sys,
    nib_regs_if.store bus
);
    logic [NUM_NIB_REGS*NIB_W-1:0] mem_q;
    assign bus.rd_all = mem_q;
    always_ff @(posedge clk_sys) begin
        if (bus.clear) begin
            mem_q <= '0;
        end else if (bus.wr_en && (int'(bus.wr_idx) < NUM_NIB_REGS)) begin
            mem_q[bus.wr_idx*NIB_W +: NIB_W] <= bus.wr_data;
        end
    end
    property p_clear_zero;
        @(posedge clk_sys) bus.clear |=> (mem_q == '0);
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("store not cleared");
endmodule // nib_reg_store

// ===== rtl/rst_backup_ctrl.sv
// Reset, power-on reset, voltage-drop reset and RAM back-up sequencer.
// Assumes instruction strobes come from the core on clk_sys; pins are asynchronous.
`timescale 1ns/10ps
module rst_backup_ctrl
    import rst_backup_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic reset_pin_n,
    input wire logic vdrop_detect,
    input wire logic wakeup_in,
    input wire logic watchdog_reset,
    input wire logic instr_valid,
    input wire logic power_down_enable_instr,
    input wire logic backup_keep_detector_instr,
    input wire logic backup_full_stop_instr,
    input wire logic skip_on_power_down_flag_instr,
    input wire logic reg_wr_en,
    input wire logic [2:0] reg_wr_idx,
    input wire logic [NIB_W-1:0] reg_wr_data,
    input wire logic pc_load,
    input wire logic [PC_W-1:0] pc_next,
    input wire logic global_interrupt_enable_set,
    input wire logic global_interrupt_enable_clr,
    input wire logic carry_in,
    input wire logic carry_wr,
    input wire logic ext0_set,
    input wire logic ext0_clr,
    input wire logic watchdog_flag_one_set,
    input wire logic watchdog_flag_two_set,
    input wire logic wdf_clr,
    input wire logic [PORT_W-1:0] port_latch_wr,
    input wire logic port_latch_wr_en,
    input wire logic [PORT_W-1:0] port_dir_wr,
    output logic core_run,
    output logic osc_enable,
    output logic vdrop_enable,
    output logic periph_enable,
    output logic [PC_W-1:0] program_counter,
    output logic global_interrupt_enable,
    output logic carry_flag,
    output logic ext0_interrupt_request,
    output logic watchdog_flag_one,
    output logic watchdog_flag_two,
    output logic power_down_flag,
    output logic skip_result,
    output logic [NIB_W-1:0] ext_interrupt_control,
    output logic [NIB_W-1:0] pullup_control_port0,
    output logic [NIB_W-1:0] pullup_control_port1,
    output logic [NIB_W-1:0] pullup_control_port2,
    output logic [NIB_W-1:0] converter_control,
    output logic [PORT_W-1:0] port_latch,
    output logic [PORT_W-1:0] port_oe,
    output logic [PU_W-1:0] pullup_on
);
    ////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic rpin_s1_q, rpin_s2_q, vd_s1_q, vd_s2_q, wk_s1_q, wk_s2_q;
    always_ff @(posedge clk_sys) begin
        rpin_s1_q <= reset_pin_n;
        rpin_s2_q <= rpin_s1_q;
        vd_s1_q <= vdrop_detect;
        vd_s2_q <= vd_s1_q;
        wk_s1_q <= wakeup_in;
        wk_s2_q <= wk_s1_q;
    end

    ////////////////////////////////////////////////////////////////
    // Power-on reset: rst models supply rising; hold for a few cycles
    logic [2:0] por_cnt_q;
    logic por_active;
    assign por_active = (por_cnt_q != 3'(POR_CYCLES));
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            por_cnt_q <= 3'h0;
        end else if (por_active) begin
            por_cnt_q <= por_cnt_q + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Reset sources and sequencer
    seq_state_e state_q, state_d;
    logic vdrop_en_now;
    logic cold_reset;
    logic is_backup_instr;
    assign vdrop_en_now = (state_q != ST_BACKUP) || vdrop_enable;
    // Detector only counts while enabled; full-stop back-up ignores it
    assign cold_reset = por_active || !rpin_s2_q || (vd_s2_q && vdrop_en_now)
        || (watchdog_reset && state_q != ST_BACKUP);
    assign is_backup_instr = instr_valid && (backup_keep_detector_instr || backup_full_stop_instr);
    logic enter_backup;
    assign enter_backup = (state_q == ST_ARMED) && is_backup_instr;
    logic wake;
    assign wake = (state_q == ST_BACKUP) && wk_s2_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RESET: state_d = ST_RUN;
            ST_RUN: if (instr_valid && power_down_enable_instr) state_d = ST_ARMED;
            ST_ARMED: begin
                if (enter_backup) begin
                    state_d = ST_BACKUP;
                end else if (instr_valid) begin
                    state_d = power_down_enable_instr ? ST_ARMED : ST_RUN;
                end
            end
            ST_BACKUP: if (wake) state_d = ST_RESET;
            default: state_d = ST_RESET;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst || cold_reset) begin
            state_q <= ST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    logic vdrop_enable_d;
    assign vdrop_enable_d = enter_backup ? (instr_valid && backup_keep_detector_instr) : vdrop_enable;
    always_ff @(posedge clk_sys) begin
        if (rst || cold_reset || wake) begin
            vdrop_enable <= 1'b1;
        end else begin
            vdrop_enable <= vdrop_enable_d;
        end
    end

    logic in_reset_d;
    assign in_reset_d = rst || cold_reset || wake || (state_d == ST_RESET);
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            core_run <= 1'b0;
            osc_enable <= 1'b1;
            periph_enable <= 1'b0;
            power_down_flag <= 1'b0;
            skip_result <= 1'b0;
        end else begin
            core_run <= !in_reset_d && (state_d != ST_BACKUP);
            osc_enable <= (state_d != ST_BACKUP) || cold_reset;
            periph_enable <= !in_reset_d && (state_d != ST_BACKUP);
            if (cold_reset) begin
                power_down_flag <= 1'b0;
            end else if (wake) begin
                power_down_flag <= 1'b1;
            end
            skip_result <= instr_valid && skip_on_power_down_flag_instr && power_down_flag;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Core state with reset values
    logic init;
    assign init = rst || cold_reset || wake || (state_q == ST_RESET);
    always_ff @(posedge clk_sys) begin
        if (init) begin
            program_counter <= PC_RESET;
            global_interrupt_enable <= 1'b0;
            carry_flag <= 1'b0;
            ext0_interrupt_request <= 1'b0;
            watchdog_flag_one <= 1'b0;
            watchdog_flag_two <= 1'b0;
            port_latch <= LATCH_RESET;
            port_oe <= '0;
        end else if (core_run) begin
            if (pc_load) program_counter <= pc_next;
            // Set wins over clear on every flag
            if (global_interrupt_enable_set) global_interrupt_enable <= 1'b1;
            else if (global_interrupt_enable_clr) global_interrupt_enable <= 1'b0;
            if (carry_wr) carry_flag <= carry_in;
            if (ext0_set) ext0_interrupt_request <= 1'b1;
            else if (ext0_clr) ext0_interrupt_request <= 1'b0;
            if (watchdog_flag_one_set) watchdog_flag_one <= 1'b1;
            else if (wdf_clr) watchdog_flag_one <= 1'b0;
            if (watchdog_flag_two_set) watchdog_flag_two <= 1'b1;
            else if (wdf_clr) watchdog_flag_two <= 1'b0;
            if (port_latch_wr_en) port_latch <= port_latch_wr;
            port_oe <= port_dir_wr;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Nibble control registers; retained through back-up
    nib_regs_if regs ();
    assign regs.clear = rst || cold_reset;
    assign regs.wr_en = reg_wr_en && core_run;
    assign regs.wr_idx = reg_wr_idx;
    assign regs.wr_data = reg_wr_data;
    nib_reg_store u_store (.clk_sys(clk_sys), .bus(regs));

    always_ff @(posedge clk_sys) begin
        ext_interrupt_control <= regs.rd_all[IDX_EXT_INT_CTRL*NIB_W +: NIB_W];
        pullup_control_port0 <= regs.rd_all[IDX_PULLUP0*NIB_W +: NIB_W];
        pullup_control_port1 <= regs.rd_all[IDX_PULLUP1*NIB_W +: NIB_W];
        pullup_control_port2 <= regs.rd_all[IDX_PULLUP2*NIB_W +: NIB_W];
        converter_control <= regs.rd_all[IDX_CONV_CTRL*NIB_W +: NIB_W];
        // Pull-ups: P0, P1, P2, D2, D3; forced off while in reset
        if (init) begin
            pullup_on <= '0;
        end else begin
            pullup_on <= {|pullup_control_port2, |pullup_control_port2,
                |pullup_control_port2, |pullup_control_port1, |pullup_control_port0};
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    property p_pin_reset;
        @(posedge clk_sys) disable iff (rst) !rpin_s2_q |=> (state_q == ST_RESET) ##0 !core_run;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin reset not applied");
    property p_pc_zero;
        @(posedge clk_sys) disable iff (rst) cold_reset |=> (program_counter == PC_RESET);
    endproperty
    a_pc_zero: assert property (p_pc_zero) else $error("pc not zero after reset");
    property p_nop;
        @(posedge clk_sys) disable iff (rst)
            (state_q == ST_RUN && is_backup_instr && !cold_reset) |=> (state_q != ST_BACKUP);
    endproperty
    a_nop: assert property (p_nop) else $error("backup without enable");
    property p_wake_flag;
        @(posedge clk_sys) disable iff (rst) (wake && !cold_reset) |=> power_down_flag;
    endproperty
    a_wake_flag: assert property (p_wake_flag) else $error("warm start flag not set");
    property p_cold_flag;
        @(posedge clk_sys) disable iff (rst) cold_reset |=> !power_down_flag;
    endproperty
    a_cold_flag: assert property (p_cold_flag) else $error("cold start flag not clear");
    property p_osc_stop;
        @(posedge clk_sys) disable iff (rst) (enter_backup && !cold_reset) |=> !osc_enable;
    endproperty
    a_osc_stop: assert property (p_osc_stop) else $error("oscillator still on in backup");
    property p_full_stop;
        @(posedge clk_sys) disable iff (rst)
            (enter_backup && backup_full_stop_instr && !backup_keep_detector_instr && !cold_reset)
            |=> !vdrop_enable && !periph_enable;
    endproperty
    a_full_stop: assert property (p_full_stop) else $error("full stop left detector on");
    property p_port_reset;
        @(posedge clk_sys) disable iff (rst) cold_reset |=> (port_oe == '0) && (port_latch == LATCH_RESET);
    endproperty
    a_port_reset: assert property (p_port_reset) else $error("ports not floating in reset");
endmodule // rst_backup_ctrl

// ===== sim/ext_pins.sv
// Model of the outside reset source and wake-up pins.
// Assumes the bench sequences it through set_pins on clk_sys.
`timescale 1ns/10ps
module ext_pins (
    input wire logic clk_sys,
    output logic reset_pin_n,
    output logic wakeup_in,
    output logic vdrop_detect
);

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        reset_pin_n = 1'b1;
        wakeup_in = 1'b0;
        vdrop_detect = 1'b0;
    end

    // Levels hold until the next call, so a low reset lasts whole cycles
    task automatic set_pins(input logic rn, input logic wk, input logic vd);
        @(posedge clk_sys);
        #1;
        reset_pin_n = rn;
        wakeup_in = wk;
        vdrop_detect = vd;
    endtask

endmodule // ext_pins

// ===== sim/reset_and_ram_backup_control_bench.sv
// Self-checking bench for the reset and RAM back-up controller.
// Assumes ext_pins drives the asynchronous pins; core strobes come from here.
`timescale 1ns/10ps
module reset_and_ram_backup_control_bench;
    import rst_backup_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Strobe map: 0 valid, 1..4 enable/keep/full/skip, 5 watchdog, 6 reg write,
    // 7 pc load, 8 global_interrupt_enable set, 9 global_interrupt_enable clr, 10 carry in, 11 carry wr, 12 ext0 set,
    // 13 ext0 clr, 14 watchdog_flag_one set, 15 watchdog_flag_two set, 16 wdf clr, 17 latch write
    logic clk_sys, rst, reset_pin_n, wakeup_in, vdrop_detect;
    logic [17:0] fl;
    logic [2:0] reg_wr_idx;
    logic [NIB_W-1:0] reg_wr_data;
    logic [PC_W-1:0] pc_next, program_counter;
    logic [PORT_W-1:0] port_latch_wr, port_dir_wr, port_latch, port_oe;
    logic core_run, osc_enable, vdrop_enable, periph_enable, global_interrupt_enable, carry_flag;
    logic ext0_interrupt_request, watchdog_flag_one, watchdog_flag_two, power_down_flag, skip_result;
    logic [NIB_W-1:0] ext_interrupt_control, pullup_control_port0, pullup_control_port1;
    logic [NIB_W-1:0] pullup_control_port2, converter_control;
    logic [PU_W-1:0] pullup_on;
    logic [4:0] core_flags;
    int miscompares = 0;
    int n_compared = 0;

    ext_pins pins_u (.clk_sys, .reset_pin_n, .wakeup_in, .vdrop_detect);

    rst_backup_ctrl dut_u (.clk_sys, .rst, .reset_pin_n, .vdrop_detect, .wakeup_in,
        .watchdog_reset(fl[5]), .instr_valid(fl[0]), .power_down_enable_instr(fl[1]),
        .backup_keep_detector_instr(fl[2]), .backup_full_stop_instr(fl[3]),
        .skip_on_power_down_flag_instr(fl[4]), .reg_wr_en(fl[6]), .reg_wr_idx, .reg_wr_data,
        .pc_load(fl[7]), .pc_next, .global_interrupt_enable_set(fl[8]), .global_interrupt_enable_clr(fl[9]), .carry_in(fl[10]),
        .carry_wr(fl[11]), .ext0_set(fl[12]), .ext0_clr(fl[13]), .watchdog_flag_one_set(fl[14]),
        .watchdog_flag_two_set(fl[15]), .wdf_clr(fl[16]), .port_latch_wr, .port_latch_wr_en(fl[17]),
        .port_dir_wr, .core_run, .osc_enable, .vdrop_enable, .periph_enable, .program_counter,
        .global_interrupt_enable, .carry_flag, .ext0_interrupt_request, .watchdog_flag_one,
        .watchdog_flag_two, .power_down_flag, .skip_result, .ext_interrupt_control,
        .pullup_control_port0, .pullup_control_port1, .pullup_control_port2,
        .converter_control, .port_latch, .port_oe, .pullup_on);

    assign core_flags = {global_interrupt_enable, carry_flag, ext0_interrupt_request, watchdog_flag_one,
        watchdog_flag_two};

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic cyc();
        @(posedge clk_sys);
        #1;
    endtask

    task automatic conclude();
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Bounded wait on core_run; running out ends the run
    task automatic wait_run(input logic v);
        int n;
        n = 0;
        while (core_run !== v && n < 60) begin
            cyc();
            n++;
        end
        if (core_run !== v) begin
            miscompares++;
            conclude();
        end
    endtask

    // Code bits: skip, full stop, keep detector, enable
    // Strobes stay up until the caller changes fl, so back-to-back calls drive fl once per step
    task automatic instr(input logic [3:0] code);
        fl = {13'h0000, code, 1'b1};
        cyc();
    endtask

    // Moves the core flags, program counter, port latch and direction and nibble registers away from their reset values
    task automatic load();
        fl = 18'h2DD80;
        cyc();
        for (int i = 0; i < NUM_NIB_REGS; i++) begin
            fl = 18'h00040;
            reg_wr_idx = 3'(i);
            cyc();
        end
        fl = '0;
        repeat (3) cyc();
        chk(core_flags, 32'h1F);
    endtask

    task automatic chk_rst();
        chk(core_run, 0);
        chk(program_counter, 0);
        chk(global_interrupt_enable, 0);
        chk({ext0_interrupt_request, watchdog_flag_one, watchdog_flag_two, carry_flag}, 0);
        chk(port_latch, {PORT_W{1'b1}});
        chk(port_oe, 0);
        chk(pullup_on, 0);
    endtask

    task automatic nib_chk(input logic [19:0] exp);
        chk({ext_interrupt_control, pullup_control_port0, pullup_control_port1,
            pullup_control_port2, converter_control}, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        fl = '0;
        reg_wr_idx = 3'h0;
        reg_wr_data = 4'hF;
        pc_next = 14'h2ABC;
        port_latch_wr = 22'h000000;
        port_dir_wr = 22'h3FFFFF;
        repeat (19) cyc();
        chk_rst();
        cyc();
        rst = 1'b0;
        wait_run(1'b1);
        chk(power_down_flag, 0);
        // Pin reset with everything loaded
        load();
        pins_u.set_pins(1'b0, 1'b0, 1'b0);
        wait_run(1'b0);
        repeat (2) cyc();
        chk_rst();
        pins_u.set_pins(1'b1, 1'b0, 1'b0);
        wait_run(1'b1);
        chk(program_counter, 0);
        repeat (2) cyc();
        nib_chk(20'h00000);
        // Back-up not straight after enable does nothing
        instr(4'h2);
        instr(4'h1);
        instr(4'h8);
        instr(4'h2);
        fl = '0;
        cyc();
        chk({core_run, osc_enable}, 2'b11);
        // Keep-detector back-up, warm start, then watchdog cold start
        load();
        instr(4'h1);
        instr(4'h2);
        fl = '0;
        cyc();
        chk({core_run, osc_enable, vdrop_enable}, 3'b001);
        pins_u.set_pins(1'b1, 1'b1, 1'b0);
        wait_run(1'b1);
        pins_u.set_pins(1'b1, 1'b0, 1'b0);
        chk({power_down_flag, program_counter}, 15'h4000);
        nib_chk(20'hFFFFF);
        instr(4'h8);
        chk(skip_result, 1);
        fl = 18'h00020;
        cyc();
        fl = '0;
        wait_run(1'b0);
        wait_run(1'b1);
        chk(power_down_flag, 0);
        instr(4'h8);
        chk(skip_result, 0);
        // Full-stop back-up ignores internal events
        instr(4'h1);
        instr(4'h4);
        fl = '0;
        cyc();
        chk({core_run, osc_enable, vdrop_enable, periph_enable}, 4'h0);
        fl = 18'h00020;
        pins_u.set_pins(1'b1, 1'b0, 1'b1);
        repeat (8) cyc();
        fl = '0;
        pins_u.set_pins(1'b1, 1'b0, 1'b0);
        repeat (8) cyc();
        chk({core_run, osc_enable}, 2'b00);
        pins_u.set_pins(1'b1, 1'b1, 1'b0);
        wait_run(1'b1);
        pins_u.set_pins(1'b1, 1'b0, 1'b0);
        chk(power_down_flag, 1);
        // Voltage drop while in keep-detector back-up gives a cold start
        instr(4'h1);
        instr(4'h2);
        fl = '0;
        pins_u.set_pins(1'b1, 1'b0, 1'b1);
        repeat (6) cyc();
        // Oscillator back on and warm-start flag gone while the drop still holds reset
        chk({osc_enable, power_down_flag, program_counter}, 16'h8000);
        pins_u.set_pins(1'b1, 1'b0, 1'b0);
        wait_run(1'b1);
        chk(power_down_flag, 0);
        // Clear strobes drop the flags; a set in the same cycle wins
        load();
        fl = 18'h12200;
        cyc();
        chk(core_flags, 32'h08);
        fl = 18'h1F300;
        cyc();
        fl = '0;
        chk(core_flags, 32'h1F);
        conclude();
    end

endmodule // reset_and_ram_backup_control_bench
